// *** logic/ppdm_data_pin_mux.sv ***
// Data pin multiplexer with strap selection, tristate control and an APB register file.
// Assumes the strap and all pin inputs are asynchronous; APB runs on sys_clk_i.
`timescale 1ns/100ps
`include "ppdm_regs.svh"
module ppdm_data_pin_mux #(
    parameter int WIDTH = 32,
    parameter int HALF  = 16
) (
    // Clock and reset.
    input  wire logic             sys_clk_i,
    input  wire logic             rst_n_i,
    // APB slave.
    input  wire logic             psel_i,
    input  wire logic             penable_i,
    input  wire logic             pwrite_i,
    input  wire logic [11:0]      paddr_i,
    input  wire logic [31:0]      pwdata_i,
    output logic      [31:0]      prdata_o,
    output logic                  pready_o,
    output logic                  pslverr_o,
    // Mode pins.
    input  wire logic             bus_function_strap_i,
    input  wire logic             hold_req_n_i,
    input  wire logic             test_rst_n_i,
    input  wire logic             debug_event_pin_a_i,
    input  wire logic             debug_event_pin_b_off_i,
    // Memory clocks.
    input  wire logic [1:0]       mem_clk_i,
    output logic      [1:0]       memory_clock_output_o,
    output logic      [1:0]       memory_clock_output_oe_o,
    // Data pins.
    input  wire logic [WIDTH-1:0] data_pin_i,
    output logic      [WIDTH-1:0] data_pin_o,
    output logic      [WIDTH-1:0] data_pin_oe_o,
    // Internal memory controller data path.
    input  wire logic [WIDTH-1:0] external_memory_iface_out_i,
    input  wire logic             external_memory_iface_drive_i,
    output logic      [WIDTH-1:0] external_memory_iface_in_o,
    // Function in force.
    output logic                  mem_function_o
);
    ppdm_pin_if pins ();

    // Two-flop synchronisers for pin inputs.
    logic [WIDTH-1:0] din_s1;
    logic [WIDTH-1:0] din_s2;
    logic [3:0]       mode_s1;
    logic [3:0]       mode_s2;
    logic             strap_s1;
    logic             strap_s2;
    logic             strap_taken;
    logic [1:0]       strap_settle;

    ppdm_pkg::ppdm_fn_e function_sel;
    logic [31:0]        external_bus_ctrl_reg;
    logic [31:0]        memory_global_ctrl_1;
    logic [31:0]        memory_global_ctrl_2;
    logic [HALF-1:0]    gpio_dir;
    logic [HALF-1:0]    gpio_out;
    logic [WIDTH-1:0]   mem_dir;
    logic [WIDTH-1:0]   mem_out;
    logic [31:0]        rdata;

    // Data pin inputs cross into the clock domain through two flops.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            din_s1 <= '0;
            din_s2 <= '0;
        end else begin
            din_s1 <= data_pin_i;
            din_s2 <= din_s1;
        end
    end

    // Mode pins cross through two flops; the reset value holds hold_req_n_i high and the other three low, so hold and off mode stay inactive.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_s1 <= 4'h1;
            mode_s2 <= 4'h1;
        end else begin
            mode_s1 <= {debug_event_pin_b_off_i, debug_event_pin_a_i, test_rst_n_i, hold_req_n_i};
            mode_s2 <= mode_s1;
        end
    end

    // The strap pin crosses through two flops.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strap_s1 <= 1'b0;
            strap_s2 <= 1'b0;
        end else begin
            strap_s1 <= bus_function_strap_i;
            strap_s2 <= strap_s1;
        end
    end

    // Counts the edges the strap needs to reach the second flop after release.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strap_settle <= 2'h0;
        end else if (strap_settle != 2'h2) begin
            strap_settle <= strap_settle + 2'h1;
        end
    end

    // The strap is taken from the second flop once it holds a sample after release, then frozen.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strap_taken  <= 1'b0;
            function_sel <= ppdm_pkg::PPDM_FN_GPIO;
        end else if (!strap_taken && (strap_settle == 2'h2)) begin
            strap_taken  <= 1'b1;
            function_sel <= strap_s2 ? ppdm_pkg::PPDM_FN_MEM : ppdm_pkg::PPDM_FN_GPIO;
        end
    end

    // Synchronised mode pins.
    wire hold_req_n_sync  = mode_s2[0];
    wire test_rst_n_sync  = mode_s2[1];
    wire debug_a_sync     = mode_s2[2];
    wire debug_b_off_sync = mode_s2[3];

    wire hold_active = ~hold_req_n_sync;
    wire off_mode    = ~test_rst_n_sync & debug_a_sync & ~debug_b_off_sync;
    wire mem_fn      = (function_sel == ppdm_pkg::PPDM_FN_MEM);
    wire pins_float  = hold_active | off_mode | ~strap_taken;

    // APB decode.
    wire        apb_wr   = psel_i & penable_i & pwrite_i;
    wire [11:0] addr     = paddr_i;
    wire        hit_bctl = (addr == `PPDM_OFF_BUS_CTRL);
    wire        hit_gc1  = (addr == `PPDM_OFF_GLB_CTRL_1);
    wire        hit_gc2  = (addr == `PPDM_OFF_GLB_CTRL_2);
    wire        hit_gdir = (addr == `PPDM_OFF_GPIO_DIR);
    wire        hit_gout = (addr == `PPDM_OFF_GPIO_OUT);
    wire        hit_gin  = (addr == `PPDM_OFF_GPIO_IN);
    wire        hit_stat = (addr == `PPDM_OFF_STATUS);
    wire        hit_mdir = (addr == `PPDM_OFF_MEM_DIR);
    wire        hit_mout = (addr == `PPDM_OFF_MEM_OUT);
    wire        hit_min  = (addr == `PPDM_OFF_MEM_IN);
    wire        hit_any  = hit_bctl | hit_gc1 | hit_gc2 | hit_gdir | hit_gout | hit_gin
                         | hit_stat | hit_mdir | hit_mout | hit_min;

    // Bus control word; bit 0 switches the bus holders.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            external_bus_ctrl_reg <= `PPDM_RST_BUS_CTRL;
        end else if (apb_wr && hit_bctl) begin
            external_bus_ctrl_reg <= pwdata_i;
        end
    end

    // Global control word 1; bit 0 floats memory clock 0 in hold.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            memory_global_ctrl_1 <= `PPDM_RST_GLB_CTRL;
        end else if (apb_wr && hit_gc1) begin
            memory_global_ctrl_1 <= pwdata_i;
        end
    end

    // Global control word 2; bit 0 floats memory clock 1 in hold.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            memory_global_ctrl_2 <= `PPDM_RST_GLB_CTRL;
        end else if (apb_wr && hit_gc2) begin
            memory_global_ctrl_2 <= pwdata_i;
        end
    end

    // General I/O direction, one bit a pin, 1 drives.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gpio_dir <= HALF'(`PPDM_RST_DIR);
        end else if (apb_wr && hit_gdir) begin
            gpio_dir <= pwdata_i[HALF-1:0];
        end
    end

    // General I/O output levels.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gpio_out <= '0;
        end else if (apb_wr && hit_gout) begin
            gpio_out <= pwdata_i[HALF-1:0];
        end
    end

    // Memory data direction, one bit a pin, 1 drives.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_dir <= WIDTH'(`PPDM_RST_DIR);
        end else if (apb_wr && hit_mdir) begin
            mem_dir <= WIDTH'(pwdata_i);
        end
    end

    // Memory data output word written by software.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_out <= '0;
        end else if (apb_wr && hit_mout) begin
            mem_out <= WIDTH'(pwdata_i);
        end
    end

    wire [31:0] status_word = {29'h0, off_mode, hold_active, mem_fn};
    assign rdata = hit_bctl ? external_bus_ctrl_reg :
                   hit_gc1  ? memory_global_ctrl_1  :
                   hit_gc2  ? memory_global_ctrl_2  :
                   hit_gdir ? {16'h0, gpio_dir}     :
                   hit_gout ? {16'h0, gpio_out}     :
                   hit_gin  ? {16'h0, din_s2[WIDTH-1:HALF]} :
                   hit_stat ? status_word           :
                   hit_mdir ? mem_dir               :
                   hit_mout ? mem_out               :
                   hit_min  ? din_s2                : 32'h0000_0000;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_o <= '0;
        end else if (psel_i & ~penable_i & ~pwrite_i) begin
            prdata_o <= rdata;
        end
    end
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~hit_any;

    // Per-pin function and direction selection.
    // Memory-side value: the controller's word while it drives, else the software word.
    function automatic logic [WIDTH-1:0] mem_drive_word(input logic             drive,
                                                        input logic [WIDTH-1:0] ctrl_word,
                                                        input logic [WIDTH-1:0] sw_word);
        mem_drive_word = drive ? ctrl_word : sw_word;
    endfunction

    wire [WIDTH-1:0] mem_val = mem_drive_word(external_memory_iface_drive_i, external_memory_iface_out_i, mem_out);
    wire [WIDTH-1:0] mem_en  = mem_dir | {WIDTH{external_memory_iface_drive_i}};
    logic [WIDTH-1:0] pin_en;
    logic [WIDTH-1:0] pin_val;

    genvar p;
    generate
        for (p = 0; p < WIDTH; p++) begin : g_sel
            if (p >= HALF) begin : g_upper
                // Upper pins carry memory data or general I/O bit p-HALF.
                assign pin_en[p]  = mem_fn ? mem_en[p] : gpio_dir[p-HALF];
                assign pin_val[p] = mem_fn ? mem_val[p] : gpio_out[p-HALF];
            end else begin : g_lower
                // Lower pins carry memory data; while reserved only their bus holder can drive them.
                assign pin_en[p]  = mem_fn & mem_en[p];
                assign pin_val[p] = mem_val[p];
            end
        end
    endgenerate

    assign pins.drive_en  = pins_float ? '0 : pin_en;
    assign pins.drive_val = pin_val;
    assign pins.holder_en = external_bus_ctrl_reg[`PPDM_BIT_HOLDER_EN] & strap_taken;

    ppdm_pad_bank #(
        .WIDTH (WIDTH)
    ) u_pads (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .pins      (pins.pads)
    );

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_pin_o    <= '0;
            data_pin_oe_o <= '0;
        end else begin
            data_pin_o    <= pins.pad_out;
            data_pin_oe_o <= pins.pad_oe;
        end
    end

    assign external_memory_iface_in_o = mem_fn ? din_s2 : '0;
    assign mem_function_o             = mem_fn;

    // Memory clocks float in reset and off mode, and in hold when their tristate bit is set.
    wire [1:0] clk_hz = {memory_global_ctrl_2[`PPDM_BIT_CLK_HZ], memory_global_ctrl_1[`PPDM_BIT_CLK_HZ]};
    assign memory_clock_output_o    = mem_clk_i;
    assign memory_clock_output_oe_o = {2{rst_n_i & ~off_mode}} & ~({2{hold_active}} & clk_hz);
endmodule // ppdm_data_pin_mux

// *** logic/ppdm_regs.svh ***
// Register offsets, field positions and reset values of the data pin multiplexer.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef PPDM_REGS_SVH
`define PPDM_REGS_SVH
`define PPDM_OFF_BUS_CTRL     12'h000
`define PPDM_OFF_GLB_CTRL_1   12'h004
`define PPDM_OFF_GLB_CTRL_2   12'h008
`define PPDM_OFF_GPIO_DIR     12'h00c
`define PPDM_OFF_GPIO_OUT     12'h010
`define PPDM_OFF_GPIO_IN      12'h014
`define PPDM_OFF_STATUS       12'h018
`define PPDM_OFF_MEM_DIR      12'h01c
`define PPDM_OFF_MEM_OUT      12'h020
`define PPDM_OFF_MEM_IN       12'h024
`define PPDM_BIT_HOLDER_EN    0
`define PPDM_BIT_CLK_HZ       0
`define PPDM_BIT_STRAP        0
`define PPDM_BIT_HOLD         1
`define PPDM_BIT_OFF          2
`define PPDM_RST_BUS_CTRL     32'h0000_0001
`define PPDM_RST_GLB_CTRL     32'h0000_0000
`define PPDM_RST_DIR          32'h0000_0000
`endif

// *** logic/ppdm_pkg.sv ***
// Types shared by the data pin multiplexer files.
// Assumes nothing of its surroundings.
package ppdm_pkg;
    typedef enum logic [0:0] {
        PPDM_FN_GPIO = 1'b0,
        PPDM_FN_MEM  = 1'b1
    } ppdm_fn_e;
    typedef logic [31:0] ppdm_word_t;
endpackage

// *** logic/ppdm_pin_if.sv ***
// Interface carrying the pin-cell controls between the multiplexer and its pad bank.
// Assumes one clock domain shared by both modules.
`timescale 1ns/100ps
interface ppdm_pin_if;
    logic [31:0] drive_val;
    logic [31:0] drive_en;
    logic        holder_en;
    logic [31:0] pad_out;
    logic [31:0] pad_oe;
    logic [31:0] hold_level;
    modport ctrl (output drive_val, output drive_en, output holder_en,
                  input pad_out, input pad_oe, input hold_level);
    modport pads (input drive_val, input drive_en, input holder_en,
                  output pad_out, output pad_oe, output hold_level);
endinterface

// *** logic/ppdm_pad_bank.sv ***
// Pad bank: output drivers and switchable bus holders for the 32 data pins.
// Assumes the wire level is resolved outside from pad_oe; holder drives when enabled and idle.
`timescale 1ns/100ps
module ppdm_pad_bank #(
    parameter int WIDTH = 32
) (
    // Clock and reset.
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    // Pin controls.
    ppdm_pin_if.pads  pins
);
    logic [WIDTH-1:0] last_level;
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_pin
            always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    last_level[g] <= 1'b0;
                end else if (pins.drive_en[g]) begin
                    last_level[g] <= pins.drive_val[g];
                end
            end
            // A holder keeps the last driven level once the driver lets go.
            assign pins.pad_out[g] = pins.drive_en[g] ? pins.drive_val[g] : last_level[g];
            assign pins.pad_oe[g]  = pins.drive_en[g] | pins.holder_en;
        end
    endgenerate
    assign pins.hold_level = last_level;
endmodule // ppdm_pad_bank

// *** sim/ppdm_mux_assertions.sv ***
// Concurrent checks on the data pin multiplexer ports.
// Assumes binding onto ppdm_data_pin_mux; mode pins pass two sync flops.
`timescale 1ns/100ps
module ppdm_mux_assertions (
    // Clock, reset and mode pins.
    input wire logic        sys_clk_i,
    input wire logic        rst_n_i,
    input wire logic        bus_function_strap_i,
    input wire logic        hold_req_n_i,
    input wire logic        test_rst_n_i,
    input wire logic        debug_event_pin_a_i,
    input wire logic        debug_event_pin_b_off_i,
    // Watched pins and outputs.
    input wire logic [1:0]  mem_clk_i,
    input wire logic [1:0]  memory_clock_output_o,
    input wire logic [1:0]  memory_clock_output_oe_o,
    input wire logic [31:0] data_pin_oe_o,
    input wire logic [31:0] external_memory_iface_in_o,
    input wire logic        mem_function_o
);
    wire off_w = !test_rst_n_i && debug_event_pin_a_i && !debug_event_pin_b_off_i;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_reset_float: assert property (disable iff (1'b0) !rst_n_i |-> data_pin_oe_o == 32'h0)
        else $error("Data pins driven during reset.");
    a_hold_float: assert property (!hold_req_n_i [*4] |-> data_pin_oe_o == 32'h0)
        else $error("Data pins driven during hold.");
    a_off_float: assert property (off_w [*4] |-> data_pin_oe_o == 32'h0)
        else $error("Data pins driven in off mode.");
    a_clk_follow: assert property (memory_clock_output_o == mem_clk_i)
        else $error("Memory clock output does not follow its source.");
    a_clk_runs: assert property ((hold_req_n_i && !off_w) [*5] |-> memory_clock_output_oe_o == 2'b11)
        else $error("Memory clock not driven outside hold.");
    a_lower_reserved: assert property (!mem_function_o |-> external_memory_iface_in_o == 32'h0)
        else $error("Memory data seen in general I/O function.");
    a_strap_capture: assert property ($rose(rst_n_i) |=> ##2 mem_function_o == $past(bus_function_strap_i, 3))
        else $error("Function differs from strap at reset release.");
    a_strap_frozen: assert property (rst_n_i [*5] |-> $stable(mem_function_o))
        else $error("Function changed outside reset.");
endmodule // ppdm_mux_assertions
bind ppdm_data_pin_mux ppdm_mux_assertions u_chk (.*);

// *** sim/ppdm_board_model.sv ***
// Board-side model that drives the data pins on request and resolves the wire.
// Assumes the mux drives a pin where its enable is high; the model yields there.
`timescale 1ns/100ps
module ppdm_board_model (
    // Clock and bench controls.
    input  wire logic        clk_i,
    input  wire logic        ext_en_i,
    input  wire logic [31:0] ext_val_i,
    // Mux pin side.
    input  wire logic [31:0] pin_val_i,
    input  wire logic [31:0] pin_oe_i,
    output logic      [31:0] wire_o
);
    logic [31:0] last = 32'h0000_0000;
    // An undriven pin shows ext_val_i while ext_en_i is set, else a level that flips every cycle.
    assign wire_o = (pin_oe_i & pin_val_i) | (~pin_oe_i & (ext_en_i ? ext_val_i : ~last));
    always_ff @(posedge clk_i) begin
        last <= wire_o;
    end
endmodule // ppdm_board_model

// *** sim/tb_top.sv ***
// Self-checking bench for the data pin multiplexer, driven over APB.
// Assumes the design files, the checker and the board model compile first.
`timescale 1ns/100ps
`include "ppdm_regs.svh"
module tb_top;
    logic        sys_clk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, bus_function_strap_i;
    logic        hold_req_n_i, test_rst_n_i, debug_event_pin_a_i, debug_event_pin_b_off_i, mem_function_o;
    logic        external_memory_iface_drive_i, ext_en, err;
    logic [1:0]  mem_clk_i, memory_clock_output_o, memory_clock_output_oe_o;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, data_pin_i, data_pin_o, data_pin_oe_o, ext_val, rd;
    logic [31:0] external_memory_iface_out_i, external_memory_iface_in_o;
    int          n_fail, compares;
    ppdm_data_pin_mux u_dut (.*);
    ppdm_board_model u_board (.clk_i(sys_clk_i), .ext_en_i(ext_en), .ext_val_i(ext_val),
        .pin_val_i(data_pin_o), .pin_oe_i(data_pin_oe_o), .wire_o(data_pin_i));
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        mem_clk_i <= mem_clk_i + 2'h1;
    end
    task automatic tally_and_finish;
        if (n_fail == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk_i);
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, 1'b0, w, a, d};
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge sys_clk_i);
            if (pready_o === 1'b1) break;
        end
        if (k == 16) begin
            n_fail++;
            tally_and_finish();
        end
        rd = prdata_o;
        err = pslverr_o;
        {psel_i, penable_i} <= 2'b00;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic do_reset(input logic s);
        @(posedge sys_clk_i);
        {rst_n_i, bus_function_strap_i} <= {1'b0, s};
        wt(5);
        chk(data_pin_oe_o, 32'h0);
        @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        wt(4);
    endtask
    initial begin
        {rst_n_i, psel_i, penable_i, pwrite_i, ext_en, external_memory_iface_drive_i} = 6'h0;
        {hold_req_n_i, test_rst_n_i, debug_event_pin_a_i, debug_event_pin_b_off_i} = 4'hd;
        {paddr_i, pwdata_i, ext_val, external_memory_iface_out_i, mem_clk_i} = '0;
        {bus_function_strap_i, n_fail, compares} = '0;
        do_reset(1'b0);
        chk(32'(mem_function_o), 32'h0);
        rd_chk(`PPDM_OFF_BUS_CTRL, 32'h1);
        rd_chk(`PPDM_OFF_GPIO_DIR, 32'h0);
        rd_chk(`PPDM_OFF_MEM_DIR, 32'h0);
        apb(1'b1, `PPDM_OFF_BUS_CTRL, 32'h0);
        {ext_en, ext_val} <= {1'b1, 32'ha5c3_0f96};
        wt(4);
        chk(data_pin_oe_o, 32'h0);
        chk(external_memory_iface_in_o, 32'h0);
        rd_chk(`PPDM_OFF_GPIO_IN, 32'h0000_a5c3);
        apb(1'b1, `PPDM_OFF_GPIO_DIR, 32'h0000_00ff);
        apb(1'b1, `PPDM_OFF_GPIO_OUT, 32'h0000_1234);
        bus_function_strap_i <= 1'b1;
        wt(4);
        chk(data_pin_oe_o, 32'h00ff_0000);
        chk(data_pin_o & 32'h00ff_0000, 32'h0034_0000);
        chk(32'(mem_function_o), 32'h0);
        hold_req_n_i <= 1'b0;
        wt(4);
        chk(data_pin_oe_o, 32'h0);
        rd_chk(`PPDM_OFF_STATUS, 32'h2);
        hold_req_n_i <= 1'b1;
        ext_en <= 1'b0;
        apb(1'b1, `PPDM_OFF_GPIO_DIR, 32'h0);
        apb(1'b1, `PPDM_OFF_BUS_CTRL, 32'h1);
        wt(4);
        chk(data_pin_oe_o, 32'hffff_ffff);
        chk(data_pin_o & 32'h00ff_0000, 32'h0034_0000);
        rd_chk(12'h040, 32'h0);
        chk(32'(err), 32'h1);
        do_reset(1'b1);
        chk(32'(mem_function_o), 32'h1);
        bus_function_strap_i <= 1'b0;
        apb(1'b1, `PPDM_OFF_BUS_CTRL, 32'h0);
        {ext_en, ext_val} <= {1'b1, 32'h1357_9bdf};
        wt(4);
        chk(data_pin_oe_o, 32'h0);
        chk(external_memory_iface_in_o, 32'h1357_9bdf);
        chk(32'(mem_function_o), 32'h1);
        ext_en <= 1'b0;
        apb(1'b1, `PPDM_OFF_MEM_DIR, 32'hffff_ffff);
        apb(1'b1, `PPDM_OFF_MEM_OUT, 32'hcafe_f00d);
        wt(3);
        chk(data_pin_o, 32'hcafe_f00d);
        {external_memory_iface_drive_i, external_memory_iface_out_i} <= {1'b1, 32'h0bad_beef};
        wt(3);
        chk(data_pin_o, 32'h0bad_beef);
        {test_rst_n_i, debug_event_pin_a_i, debug_event_pin_b_off_i} <= 3'b010;
        wt(4);
        chk(data_pin_oe_o, 32'h0);
        {test_rst_n_i, debug_event_pin_a_i, debug_event_pin_b_off_i} <= 3'b101;
        apb(1'b1, `PPDM_OFF_GLB_CTRL_1, 32'h1);
        hold_req_n_i <= 1'b0;
        wt(4);
        chk(32'(memory_clock_output_oe_o), 32'h2);
        apb(1'b1, `PPDM_OFF_GLB_CTRL_1, 32'h0);
        apb(1'b1, `PPDM_OFF_GLB_CTRL_2, 32'h1);
        wt(1);
        chk(32'(memory_clock_output_oe_o), 32'h1);
        tally_and_finish();
    end
endmodule // tb_top
